// [logic/mac_command_and_irq_status.sv]
// command register and interrupt event flags of a paged ethernet core
// assumes a synchronous local bus: one-cycle write strobe, read data a cycle later
//
// Contract
// RULE1: page selector picks page zero or one
// RULE2: remote dma code 001 read, 010 write
// RULE3: top dma command bit aborts transfer
// RULE4: device clears top bit when dma finishes
// RULE5: host clears byte count after abort
// RULE6: abort keeps current remote address
// RULE7: transmit bit starts packet transmission
// RULE8: start bit activates controller
// RULE9: stop bit halts controller
// RULE10: reset flag set on reset, cleared by start
// RULE11: reset flag never requests interrupt
// RULE12: dma done sets its flag
// RULE13: tally msb sets overflow flag
// RULE14: ring exhausted sets overwrite flag
// RULE15: collisions or underrun set transmit error
// RULE16: crc, align, overrun, missed set receive error
// RULE17: good transmit sets success flag
// RULE18: good receive sets success flag
// RULE19: write one clears event flag
// RULE20: eight-bit registers reached through page
// RULE21: mask enables cleared after reset
// RULE22: interrupt while flag and enable set
`timescale 1ns/1ns
module mac_command_and_irq_status
   import mac_cmd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // local cpu register port
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // core events and status
   input wire mac_events_t events,
   input wire logic rdma_active,
   // controls and interrupt
   output mac_ctrl_t ctrl,
   output logic irq
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0] cmd_q;
   logic [1:0] page_q;
   logic [2:0] rdma_cmd_q;
   logic txp_q;
   logic start_q;
   logic stop_q;
   localparam logic [7:0] CMD_INIT = `CMD_RESET_VAL;
   logic [7:0] mask_q;
   logic [7:0] flags;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic running_q;
   logic [7:0] rdata_q;
   logic hit_q;
   logic txp_busy_q;
   logic [5:0] pulses_q;
   rdma_state_t rdma_q;
   logic wr_cmd;
   logic wr_flags;
   logic wr_mask;

   function automatic logic addr_is(input logic [4:0] a, input logic [4:0] off);
      addr_is = (a == off);
   endfunction : addr_is

   // page-zero test, shared by the write decode and the read path
   function automatic logic on_page_zero(input logic [1:0] pg);
      on_page_zero = (pg == `PAGE_ZERO);
   endfunction : on_page_zero

   // remote dma code field of a command byte
   function automatic logic [2:0] dma_code(input logic [7:0] b);
      dma_code = b[`CMD_RDMA_HI:`CMD_RDMA_LO];
   endfunction : dma_code

   // a start that is not overridden by a stop in the same byte
   function automatic logic start_only(input logic [7:0] b);
      start_only = b[`CMD_START_BIT] & ~b[`CMD_STOP_BIT];
   endfunction : start_only

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // RULE20 paged decode
   // command is on every page, the others only on page zero
   always_comb
   begin
      wr_cmd = 1'b0;
      wr_flags = 1'b0;
      wr_mask = 1'b0;
      if (!reg_wr)
         wr_cmd = 1'b0;
      else if (addr_is(reg_addr, `OFF_CORE_COMMAND))
         wr_cmd = 1'b1;
      else if (!on_page_zero(page_q))
         wr_cmd = 1'b0;
      else if (addr_is(reg_addr, `OFF_EVENT_FLAGS))
         wr_flags = 1'b1;
      else if (addr_is(reg_addr, `OFF_ENABLE_MASK))
         wr_mask = 1'b1;
   end

   // ------------------------------------------------------------
   // command register, one flop group per field except start and stop, which share one
   // ------------------------------------------------------------
   // RULE1 page select store
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         page_q <= CMD_INIT[`CMD_PAGE_HI:`CMD_PAGE_LO];
      else if (clk_en && wr_cmd)
         page_q <= reg_wdata[`CMD_PAGE_HI:`CMD_PAGE_LO];
   end

   // RULE2 dma code store
   // a host write wins over the self-clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdma_cmd_q <= CMD_INIT[`CMD_RDMA_HI:`CMD_RDMA_LO];
      else if (clk_en)
      begin
         if (wr_cmd)
            rdma_cmd_q <= dma_code(reg_wdata);
         // RULE4 self-clear on done
         else if (events.rdma_complete)
            rdma_cmd_q[`CMD_RDMA_HI-`CMD_RDMA_LO] <= 1'b0;
      end
   end

   // RULE7 transmit bit holds
   // the bit stays set until the packet ends, so a second go cannot restart it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         txp_q <= CMD_INIT[`CMD_TXP_BIT];
      else if (clk_en)
      begin
         if (wr_cmd)
            txp_q <= reg_wdata[`CMD_TXP_BIT] | txp_q;
         else if (txp_busy_q && (events.tx_ok || events.tx_excess_coll || events.tx_underrun))
            txp_q <= 1'b0;
      end
   end

   // start and stop bits read back as last written
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         start_q <= CMD_INIT[`CMD_START_BIT];
         stop_q <= CMD_INIT[`CMD_STOP_BIT];
      end
      else if (clk_en && wr_cmd)
      begin
         start_q <= reg_wdata[`CMD_START_BIT];
         stop_q <= reg_wdata[`CMD_STOP_BIT];
      end
   end

   assign cmd_q = {page_q, rdma_cmd_q, txp_q, start_q, stop_q};

   // transmit in progress, a copy of the transmit bit one cycle late, so it clears a cycle after that bit clears
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         txp_busy_q <= 1'b0;
      else if (clk_en)
         txp_busy_q <= cmd_q[`CMD_TXP_BIT];
   end

   // ------------------------------------------------------------
   // run state and command pulses
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         running_q <= 1'b0;
      else if (clk_en && wr_cmd)
      begin
         // RULE9 stop halts
         if (reg_wdata[`CMD_STOP_BIT])
            running_q <= 1'b0;
         // RULE8 start activates
         else if (reg_wdata[`CMD_START_BIT])
            running_q <= 1'b1;
      end
   end

   // pulses are registered so the engines see one clean cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pulses_q <= 6'h00;
      else if (clk_en)
      begin
         pulses_q <= 6'h00;
         if (wr_cmd)
         begin
            // RULE2 read and write launch
            pulses_q[5] <= dma_code(reg_wdata) == `RDMA_READ;
            pulses_q[4] <= dma_code(reg_wdata) == `RDMA_WRITE;
            // RULE3 abort on top bit
            pulses_q[3] <= reg_wdata[`CMD_RDMA_HI] & rdma_active;
            // RULE7 transmit launch
            pulses_q[2] <= reg_wdata[`CMD_TXP_BIT] & ~txp_q;
            pulses_q[1] <= start_only(reg_wdata);
            pulses_q[0] <= reg_wdata[`CMD_STOP_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // remote dma tracker
   // ------------------------------------------------------------
   // RULE6 abort keeps address
   // the address counter lives outside; an abort only stops it, never reloads
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdma_q <= RDMA_IDLE;
      else if (clk_en)
      begin
         case (rdma_q)
            RDMA_IDLE:
               if (pulses_q[5] || pulses_q[4])
                  rdma_q <= RDMA_BUSY;
            RDMA_BUSY:
               if (events.rdma_complete || pulses_q[3])
                  rdma_q <= RDMA_DONE;
            RDMA_DONE:
               rdma_q <= RDMA_IDLE;
            default:
               rdma_q <= RDMA_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------
   always_comb
   begin
      flag_set = 8'h00;
      // RULE10 reset sets flag
      flag_set[7] = events.enter_reset;
      // RULE12 dma done
      flag_set[6] = events.rdma_complete;
      // RULE13 tally overflow
      flag_set[5] = events.tally_msb_set;
      // RULE14 ring overwrite
      flag_set[4] = events.ring_exhausted;
      // RULE15 transmit error
      flag_set[3] = events.tx_excess_coll | events.tx_underrun;
      // RULE16 receive error
      flag_set[2] = events.rx_crc_err | events.rx_align_err | events.rx_overrun | events.rx_missed;
      // RULE17 transmit success
      flag_set[1] = events.tx_ok;
      // RULE18 receive success
      flag_set[0] = events.rx_ok;
      // RULE19 write one clears
      flag_clr = wr_flags ? (reg_wdata & `EVT_EVENT_MASK) : 8'h00;
      // RULE10 start clears reset flag
      flag_clr[`EVT_RST_BIT] = wr_cmd & start_only(reg_wdata);
   end

   event_flag_reg u_flags (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .set_bits(flag_set),
      .clear_bits(flag_clr),
      .flags_q(flags)
   );

   // ------------------------------------------------------------
   // interrupt mask and request
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      // RULE21 enables cleared on reset
      if (sys_rst)
         mask_q <= `MASK_RESET_VAL;
      else if (clk_en && wr_mask)
         mask_q <= reg_wdata & `EVT_EVENT_MASK;
   end

   // RULE22 masked request
   // RULE11 reset flag excluded
   assign irq = |(flags & mask_q & `EVT_EVENT_MASK);

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // RULE20 paged readback
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rdata_q <= 8'h00;
         hit_q <= 1'b0;
      end
      else if (clk_en)
      begin
         hit_q <= 1'b0;
         if (!reg_rd)
            rdata_q <= rdata_q;
         else if (addr_is(reg_addr, `OFF_CORE_COMMAND))
         begin
            rdata_q <= cmd_q;
            hit_q <= 1'b1;
         end
         else if (on_page_zero(page_q) && addr_is(reg_addr, `OFF_EVENT_FLAGS))
         begin
            rdata_q <= flags;
            hit_q <= 1'b1;
         end
         else
            rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_hit = hit_q;

   // ------------------------------------------------------------
   // control outputs
   // ------------------------------------------------------------
   // RULE5 byte count left to host
   // abort does not touch the byte count; software clears it afterwards
   // one process drives the whole struct, so no member has a second driver
   always_comb
   begin
      ctrl.page = page_q;
      ctrl.rdma_read_go = pulses_q[5];
      ctrl.rdma_write_go = pulses_q[4];
      ctrl.rdma_abort = pulses_q[3];
      ctrl.transmit_packet_go = pulses_q[2];
      ctrl.start_pulse = pulses_q[1];
      ctrl.stop_pulse = pulses_q[0];
      ctrl.running = running_q;
   end
endmodule : mac_command_and_irq_status

// [logic/mac_cmd_params.svh]
// register offsets, field positions and reset values of the command and event-flag bank
// assumes inclusion from the package and the design modules only
`ifndef MAC_CMD_PARAMS_SVH
`define MAC_CMD_PARAMS_SVH

// ------------------------------------------------------------
// register offsets within a page
// ------------------------------------------------------------
`define OFF_CORE_COMMAND 5'h00
`define OFF_EVENT_FLAGS 5'h07
`define OFF_ENABLE_MASK 5'h0f

// ------------------------------------------------------------
// command register fields
// ------------------------------------------------------------
`define CMD_PAGE_HI 7
`define CMD_PAGE_LO 6
`define CMD_RDMA_HI 5
`define CMD_RDMA_LO 3
`define CMD_TXP_BIT 2
`define CMD_START_BIT 1
`define CMD_STOP_BIT 0
`define CMD_RESET_VAL 8'h21

// ------------------------------------------------------------
// event flag fields
// ------------------------------------------------------------
`define EVT_RST_BIT 7
`define EVT_EVENT_MASK 8'h7f
`define EVT_RESET_VAL 8'h80
`define MASK_RESET_VAL 8'h00
`define PAGE_ZERO 2'h0
`define PAGE_ONE 2'h1
`define RDMA_READ 3'h1
`define RDMA_WRITE 3'h2

`endif

// [logic/mac_cmd_pkg.sv]
// types shared by the command and event-flag bank
// assumes the params header sits beside it
package mac_cmd_pkg;
`include "mac_cmd_params.svh"

   typedef enum logic [1:0] {
      RDMA_IDLE = 2'b00,
      RDMA_BUSY = 2'b01,
      RDMA_DONE = 2'b11
   } rdma_state_t;

   // events raised by the mac engines, one-cycle pulses
   typedef struct packed {
      logic rdma_complete;
      logic tally_msb_set;
      logic ring_exhausted;
      logic tx_excess_coll;
      logic tx_underrun;
      logic rx_crc_err;
      logic rx_align_err;
      logic rx_overrun;
      logic rx_missed;
      logic tx_ok;
      logic rx_ok;
      logic enter_reset;
   } mac_events_t;

   // controls presented to the rest of the core
   typedef struct packed {
      logic [1:0] page;
      logic rdma_read_go;
      logic rdma_write_go;
      logic rdma_abort;
      logic transmit_packet_go;
      logic start_pulse;
      logic stop_pulse;
      logic running;
   } mac_ctrl_t;
endpackage : mac_cmd_pkg

// [logic/event_flag_reg.sv]
// eight-bit sticky flag register with write-one-to-clear
// assumes set pulses and clear strobes come from the same clock
`timescale 1ns/1ns
module event_flag_reg
   import mac_cmd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // set and clear
   input wire logic [7:0] set_bits,
   input wire logic [7:0] clear_bits,
   // state
   output logic [7:0] flags_q
);
   // set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         flags_q <= `EVT_RESET_VAL;
      else if (clk_en)
         flags_q <= (flags_q & ~clear_bits) | set_bits;
   end
endmodule : event_flag_reg

// [verification/mac_cmd_asserts.sv]
// port assertions for the command and event-flag bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module mac_cmd_checker
   import mac_cmd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // core side
   input wire mac_events_t events,
   input wire logic rdma_active,
   input wire mac_ctrl_t ctrl,
   input wire logic irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire logic cw = reg_wr && clk_en && reg_addr == 5'h00;
   // ----
   // command and flags
   // ----
   page_sel_a: assert property (cw |=> ctrl.page == $past(reg_wdata[7:6]))
      else $error("page not taken");
   dma_code_a: assert property (cw && !reg_wdata[0] |=>
      ctrl.rdma_read_go == ($past(reg_wdata[5:3]) == 3'h1) &&
      ctrl.rdma_write_go == ($past(reg_wdata[5:3]) == 3'h2)) else $error("bad dma go");
   dma_abort_a: assert property (cw && reg_wdata[5] && rdma_active |=> ctrl.rdma_abort)
      else $error("no abort");
   start_go_a: assert property (cw && reg_wdata[1:0] == 2'b10 |=>
      ctrl.start_pulse && ctrl.running) else $error("no start");
   stop_go_a: assert property (cw && reg_wdata[0] |=> ctrl.stop_pulse && !ctrl.running)
      else $error("no stop");
   // a read right behind the start write must already see the flag gone
   rst_clear_a: assert property (cw && reg_wdata[1:0] == 2'b10 && !events.enter_reset ##1
      clk_en && reg_rd && reg_addr == 5'h07 && ctrl.page == 2'h0 |=> !reg_rdata[7])
      else $error("reset flag kept");
   irq_cause_a: assert property ($rose(irq) |->
      $past(reg_wr) || $past(events[11:1]) != 11'h000) else $error("irq without cause");
   unmapped_a: assert property (clk_en && reg_rd && reg_addr == 5'h01 |=>
      !reg_hit && reg_rdata == 8'h00) else $error("unmapped hit");
endmodule : mac_cmd_checker
bind mac_command_and_irq_status mac_cmd_checker u_chk (
   .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
   .events(events), .rdma_active(rdma_active), .ctrl(ctrl), .irq(irq));

// [verification/mac_engine_model.sv]
// behavioural mac engines answering the bank's command pulses
// assumes the bank's clock; inj carries events the bench forces
`timescale 1ns/1ns
module mac_engine_model
   import mac_cmd_pkg::*;
(
   // clock
   input wire logic clk,
   // bank side
   input wire mac_ctrl_t ctrl,
   input wire mac_events_t inj,
   output mac_events_t events,
   output logic rdma_active,
   output logic busy
);
   logic [3:0] dma_q = 4'h0;
   logic [1:0] tx_q = 2'h0;
   // ----
   // engines
   // ----
   // abort drops the transfer, no completion
   // the remaining count is dropped, as the host clears it after an abort
   always @(posedge clk)
      dma_q <= ctrl.rdma_abort ? 4'h0 : {dma_q[2:0], ctrl.rdma_read_go | ctrl.rdma_write_go};
   // packet out two cycles after go
   always @(posedge clk)
      tx_q <= {tx_q[0], ctrl.transmit_packet_go};
   always_comb
   begin
      events = inj;
      events.rdma_complete = inj.rdma_complete | dma_q[3];
      events.tx_ok = inj.tx_ok | tx_q[1];
   end
   assign rdma_active = |dma_q[2:0];
   assign busy = |{dma_q, tx_q, ctrl.rdma_read_go, ctrl.rdma_write_go, ctrl.transmit_packet_go};
endmodule : mac_engine_model

// [verification/mac_command_and_irq_status_tb.sv]
// self-checking bench for the command and event-flag bank
// assumes the engine model on the core side
`timescale 1ns/1ns
module mac_command_and_irq_status_tb
   import mac_cmd_pkg::*;
;
   logic clk, sys_rst, clk_en, reg_wr, reg_rd;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic reg_hit, irq, rdma_active, busy;
   mac_events_t events, inj;
   mac_ctrl_t ctrl;
   int miscompares, n_compared, i, k;
   wire logic [7:0] pv = {ctrl.page, ctrl.rdma_read_go, ctrl.rdma_write_go,
      ctrl.transmit_packet_go, ctrl.start_pulse, ctrl.stop_pulse, ctrl.running};
   // command byte, then expected page, go pulses and running
   logic [15:0] rows [8] = '{16'h0a25, 16'h1215, 16'h0205, 16'h1a05,
      16'h060d, 16'h4245, 16'h4142, 16'h0000};
   logic [2:0] ebit [11:1] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h0};
   mac_command_and_irq_status dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .events(events),
      .rdma_active(rdma_active), .ctrl(ctrl), .irq(irq));
   mac_engine_model far (.clk(clk), .ctrl(ctrl), .inj(inj), .events(events),
      .rdma_active(rdma_active), .busy(busy));
   always #20 clk = ~clk;
   // ----
   // tasks
   // ----
   task automatic chk(input logic [7:0] got, input logic [7:0] x);
      n_compared++;
      if (got !== x)
      begin
         miscompares++;
         $display("ERROR %0t got %h want %h", $time, got, x);
      end
   endtask : chk
   task automatic results;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // one bus cycle launched at an edge; every bus and injected event input set once per edge
   task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d,
      input logic [11:0] e);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      inj <= mac_events_t'(e);
   endtask : op
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d, 12'h000);
      op(1'b0, 1'b0, a, d, 12'h000);
      #1;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] x);
      op(1'b0, 1'b1, a, 8'h00, 12'h000);
      op(1'b0, 1'b0, a, 8'h00, 12'h000);
      #1 chk(reg_rdata, x);
   endtask : rd
   task automatic idle;
      for (k = 0; k < 40 && busy; k++)
         @(negedge clk);
      if (busy)
      begin
         miscompares++;
         $display("ERROR %0t engine stuck", $time);
         results();
      end
   endtask : idle
   task automatic rst_chk;
      chk(pv, 8'h00);
      chk({7'h00, irq}, 8'h00);
      rd(5'h00, 8'h21);
      rd(5'h07, 8'h80);
   endtask : rst_chk
   // ----
   // sequence
   // ----
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      inj = '0;
      miscompares = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rst_chk();
      for (i = 0; i < 8; i++)
      begin
         wr(5'h00, rows[i][15:8]);
         chk(pv, rows[i][7:0]);
         idle();
      end
      wr(5'h07, 8'hff);
      wr(5'h0f, 8'hff);
      rd(5'h07, 8'h00);
      for (i = 1; i < 12; i++)
      begin
         op(1'b0, 1'b0, 5'h00, 8'h00, 12'h001 << i);
         rd(5'h07, 8'h01 << ebit[i]);
         chk({7'h00, irq}, 8'h01);
         wr(5'h07, 8'h00);
         rd(5'h07, 8'h01 << ebit[i]);
         wr(5'h07, 8'h01 << ebit[i]);
         rd(5'h07, 8'h00);
         chk({7'h00, irq}, 8'h00);
      end
      op(1'b0, 1'b0, 5'h00, 8'h00, 12'h001);
      rd(5'h07, 8'h80);
      chk({7'h00, irq}, 8'h00);
      op(1'b0, 1'b0, 5'h00, 8'h00, 12'h002);
      rd(5'h07, 8'h81);
      wr(5'h0f, 8'h00);
      chk({7'h00, irq}, 8'h00);
      op(1'b1, 1'b0, 5'h00, 8'h02, 12'h000);
      rd(5'h07, 8'h01);
      // a second go while the first packet is still out launches a start pulse but no transmit
      wr(5'h00, 8'h06);
      wr(5'h00, 8'h06);
      chk(pv, 8'h05);
      idle();
      wr(5'h00, 8'h0a);
      wr(5'h00, 8'h22);
      chk({7'h00, ctrl.rdma_abort}, 8'h01);
      idle();
      rd(5'h00, 8'h22);
      op(1'b0, 1'b0, 5'h00, 8'h00, 12'h800);
      rd(5'h00, 8'h02);
      rd(5'h01, 8'h00);
      chk({7'h00, reg_hit}, 8'h00);
      wr(5'h00, 8'h42);
      rd(5'h07, 8'h00);
      chk({7'h00, reg_hit}, 8'h00);
      rd(5'h00, 8'h42);
      chk({7'h00, reg_hit}, 8'h01);
      idle();
      // a frozen bank ignores the bus and holds every flop
      clk_en <= 1'b0;
      wr(5'h00, 8'h0a);
      chk(pv, 8'h41);
      clk_en <= 1'b1;
      rd(5'h00, 8'h42);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rst_chk();
      results();
   end
endmodule : mac_command_and_irq_status_tb
